// ===== pkg/pbt_pkg.sv
package pbt_pkg;
    // -----------------------------------------------------------------
    // register map (byte addresses)
    // -----------------------------------------------------------------
    localparam logic [11:0] PBT_OFS_CTRL = 12'h000;
    localparam logic [11:0] PBT_OFS_STAT = 12'h004;
    localparam logic [11:0] PBT_OFS_ATT = 12'h008;
    // control bits
    localparam int PBT_C_MAM = 0;
    localparam int PBT_C_SERR_EN = 1;
    localparam int PBT_C_DIS_PWMA = 2;
    localparam int PBT_C_DIS_DWLIM = 3;
    localparam int PBT_C_DIS_PWTA = 4;
    localparam int PBT_C_DIS_PWLIM = 5;
    localparam logic [5:0] PBT_CTRL_RST = 6'h00;
    // status bits, primary bank at 0, secondary bank at PBT_SEC_OFS
    localparam int PBT_S_RMA = 0;
    localparam int PBT_S_RTA = 1;
    localparam int PBT_S_STA = 2;
    localparam int PBT_S_SSE = 3;
    localparam logic [2:0] PBT_SEC_OFS = 3'h4;
    localparam logic [7:0] PBT_STAT_RST = 8'h00;
    // -----------------------------------------------------------------
    // target bus constants
    // -----------------------------------------------------------------
    localparam logic [2:0] PBT_DEVSEL_WAIT = 3'h5;
    localparam int PBT_RETRY_LIMIT = 1 << 24;
    localparam logic [3:0] PBT_CMD_MW = 4'h7;
    localparam logic [3:0] PBT_CMD_MWI = 4'hF;
    localparam logic [31:0] PBT_ALL_ONES = 32'hFFFF_FFFF;

    typedef enum logic [1:0] {PBT_K_DW, PBT_K_DR, PBT_K_PW, PBT_K_SC} pbt_kind_t;
    typedef enum logic [2:0] {
        PBT_A_NONE, PBT_A_TRDY, PBT_A_RETRY, PBT_A_DISC, PBT_A_TABORT
    } pbt_ans_t;

    // queued transaction handed to the initiator engine
    typedef struct packed {
        pbt_kind_t kind;
        logic [31:0] addr;
        logic [3:0] cmd;
        logic [7:0] ndw;
        logic multi;
        logic up;
    } pbt_req_t;

    // sampled target response, active high
    typedef struct packed {
        logic devsel;
        logic trdy;
        logic stop;
    } pbt_tin_t;

    typedef struct packed {
        logic frame;
        logic act;
        logic [31:0] addr;
        logic [3:0] cmd;
    } pbt_tout_t;

    // answer to the original initiator
    typedef struct packed {
        logic valid;
        pbt_ans_t ans;
        logic [31:0] data;
    } pbt_ians_t;
endpackage : pbt_pkg

// ===== core/pbt_term.sv
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module pbt_term #(
    parameter int RETRY_LIMIT = pbt_pkg::PBT_RETRY_LIMIT
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // transaction queue
    input wire logic req_valid,
    input wire pbt_pkg::pbt_req_t req,
    output logic req_ready,
    // target bus
    input wire pbt_pkg::pbt_tin_t tgt_in,
    output pbt_pkg::pbt_tout_t tgt_out,
    // initiator bus
    input wire logic ini_attempt,
    input wire logic ini_expired,
    output pbt_pkg::pbt_ians_t ini_ans,
    // system error, active low pulse
    output logic sys_err_n
);
    import pbt_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_DATA, S_GAP, S_DONE} pbt_st_t;

    pbt_st_t st_q, st_d;
    pbt_req_t req_q;
    logic [31:0] addr_q;
    logic [3:0] cmd_q;
    logic [7:0] left_q;
    logic moved_q;
    logic [2:0] cnt_q;
    logic [24:0] att_q;
    pbt_ans_t ans_q, ans_d;
    logic [31:0] data_q, data_d;
    logic [5:0] ctrl_q;
    logic [7:0] stat_q, stat_set, stat_clr;
    logic serr_d;
    logic ev_ma, ev_retry, ev_disc_pw, lim_hit;
    logic is_dly;
    logic [2:0] tb, ib;

    // -----------------------------------------------------------------
    // termination decode
    // -----------------------------------------------------------------
    assign is_dly = (req_q.kind == PBT_K_DW) || (req_q.kind == PBT_K_DR);
    // target bus is primary when forwarding upstream
    assign tb = req_q.up ? 3'h0 : PBT_SEC_OFS;
    assign ib = req_q.up ? PBT_SEC_OFS : 3'h0;
    assign lim_hit = att_q == 25'(RETRY_LIMIT - 1);

    always_comb begin
        st_d = st_q;
        ans_d = ans_q;
        data_d = data_q;
        stat_set = '0;
        serr_d = 1'b0;
        ev_ma = 1'b0;
        ev_retry = 1'b0;
        ev_disc_pw = 1'b0;
        unique case (st_q)
            S_IDLE: begin
                if (req_valid) begin
                    // fresh request: no stale answer or all-ones data carried over
                    ans_d = PBT_A_NONE;
                    data_d = '0;
                    st_d = S_ADDR;
                end
            end
            S_ADDR: begin
                if (tgt_in.devsel) begin
                    st_d = S_DATA;
                end else if (cnt_q == PBT_DEVSEL_WAIT - 3'h1) begin
                    ev_ma = 1'b1;
                    if (req_q.kind == PBT_K_SC) begin
                        // expected ending, no status touched
                        ans_d = req_q.multi ? PBT_A_DISC : PBT_A_TRDY;
                        st_d = S_DONE;
                    end else begin
                        stat_set[tb + PBT_S_RMA] = 1'b1;
                        if (req_q.kind == PBT_K_PW) begin
                            st_d = S_IDLE;
                            if (ctrl_q[PBT_C_MAM] && ctrl_q[PBT_C_SERR_EN]
                                && !ctrl_q[PBT_C_DIS_PWMA]) begin
                                serr_d = 1'b1;
                            end
                        end else if (!ctrl_q[PBT_C_MAM]) begin
                            ans_d = PBT_A_TRDY;
                            data_d = PBT_ALL_ONES;
                            st_d = S_DONE;
                        end else begin
                            ans_d = PBT_A_TABORT;
                            stat_set[ib + PBT_S_STA] = 1'b1;
                            st_d = S_DONE;
                        end
                    end
                end
            end
            S_DATA: begin
                if (tgt_in.stop && !tgt_in.devsel) begin
                    stat_set[tb + PBT_S_RTA] = 1'b1;
                    if (req_q.kind == PBT_K_PW) begin
                        st_d = S_IDLE;
                        if (ctrl_q[PBT_C_SERR_EN] && !ctrl_q[PBT_C_DIS_PWTA]) begin
                            serr_d = 1'b1;
                        end
                    end else begin
                        ans_d = PBT_A_TABORT;
                        stat_set[ib + PBT_S_STA] = 1'b1;
                        st_d = S_DONE;
                    end
                end else if (tgt_in.stop && !tgt_in.trdy && !moved_q) begin
                    ev_retry = 1'b1;
                    if (lim_hit) begin
                        if (req_q.kind == PBT_K_PW) begin
                            st_d = S_IDLE;
                            serr_d = ctrl_q[PBT_C_SERR_EN] && !ctrl_q[PBT_C_DIS_PWLIM];
                        end else begin
                            // request dropped, next attempt sees abort
                            ans_d = PBT_A_TABORT;
                            stat_set[ib + PBT_S_STA] = 1'b1;
                            serr_d = ctrl_q[PBT_C_SERR_EN]
                                && !ctrl_q[PBT_C_DIS_DWLIM];
                            st_d = S_DONE;
                        end
                    end else begin
                        st_d = S_GAP;
                    end
                end else if (tgt_in.trdy && left_q == 8'h01) begin
                    if (req_q.kind == PBT_K_PW) begin
                        st_d = S_IDLE;
                    end else begin
                        ans_d = req_q.multi ? PBT_A_DISC : PBT_A_TRDY;
                        st_d = S_DONE;
                    end
                end else if (tgt_in.stop) begin
                    if (req_q.kind == PBT_K_PW) begin
                        ev_disc_pw = 1'b1;
                        st_d = S_GAP;
                    end else begin
                        ans_d = req_q.multi ? PBT_A_DISC : PBT_A_TRDY;
                        st_d = S_DONE;
                    end
                end
            end
            S_GAP: begin
                st_d = S_ADDR;
            end
            S_DONE: begin
                // held answer is lost if the initiator never comes back
                if (ini_attempt || ini_expired) begin
                    st_d = S_IDLE;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
        if (serr_d) begin
            stat_set[PBT_S_SSE] = 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // engine state
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            ans_q <= PBT_A_NONE;
            data_q <= '0;
            req_ready <= 1'b1;
            sys_err_n <= 1'b1;
        end else begin
            st_q <= st_d;
            ans_q <= ans_d;
            data_q <= data_d;
            req_ready <= st_d == S_IDLE;
            sys_err_n <= !serr_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= '0;
            addr_q <= '0;
            cmd_q <= '0;
            left_q <= '0;
            moved_q <= 1'b0;
            cnt_q <= '0;
            att_q <= '0;
        end else begin
            cnt_q <= (st_q == S_ADDR) ? cnt_q + 3'h1 : 3'h0;
            if (st_q == S_IDLE && req_valid) begin
                req_q <= req;
                addr_q <= req.addr;
                cmd_q <= req.cmd;
                // delayed and special transfers move one dword only
                left_q <= (req.kind == PBT_K_PW) ? req.ndw : 8'h01;
                att_q <= '0;
            end
            if (st_q == S_ADDR) begin
                moved_q <= 1'b0;
            end
            if (st_q == S_DATA && tgt_in.devsel && tgt_in.trdy) begin
                addr_q <= addr_q + 32'h4;
                left_q <= left_q - 8'h01;
                moved_q <= 1'b1;
            end
            if (ev_retry) begin
                att_q <= att_q + 25'h1;
            end
            if (ev_disc_pw && cmd_q == PBT_CMD_MWI) begin
                cmd_q <= PBT_CMD_MW;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgt_out <= '0;
        end else begin
            tgt_out.frame <= st_d == S_ADDR;
            tgt_out.act <= (st_d == S_ADDR) || (st_d == S_DATA);
            tgt_out.addr <= (st_q == S_IDLE) ? req.addr : addr_q;
            tgt_out.cmd <= (st_q == S_IDLE) ? req.cmd
                : (ev_disc_pw && cmd_q == PBT_CMD_MWI) ? PBT_CMD_MW : cmd_q;
            if (st_q == S_DATA && tgt_in.devsel && tgt_in.trdy) begin
                tgt_out.addr <= addr_q + 32'h4;
            end
        end
    end

    // -----------------------------------------------------------------
    // initiator answer
    // -----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ini_ans <= '0;
        end else begin
            ini_ans.valid <= ini_attempt;
            ini_ans.data <= '0;
            if (!ini_attempt || st_q == S_IDLE) begin
                ini_ans.ans <= PBT_A_NONE;
            end else if (st_q == S_DONE) begin
                ini_ans.ans <= ans_q;
                ini_ans.data <= data_q;
            end else begin
                ini_ans.ans <= PBT_A_RETRY;
            end
        end
    end

    // -----------------------------------------------------------------
    // apb registers
    // -----------------------------------------------------------------
    logic wr_acc;
    assign wr_acc = psel && penable && pready && pwrite;
    assign stat_clr = (wr_acc && paddr == PBT_OFS_STAT) ? pwdata[7:0] : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= PBT_CTRL_RST;
        end else if (wr_acc && paddr == PBT_OFS_CTRL) begin
            ctrl_q <= pwdata[5:0];
        end
    end

    // set beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= PBT_STAT_RST;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    // zero wait state: answer in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable) begin
                unique case (paddr)
                    PBT_OFS_CTRL: prdata <= {26'h0, ctrl_q};
                    PBT_OFS_STAT: prdata <= {24'h0, stat_q};
                    PBT_OFS_ATT: prdata <= {7'h0, att_q};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_devsel_timeout: assert property ((st_q == S_ADDR && !tgt_in.devsel)[*5]
        |=> st_q != S_ADDR && st_q != S_DATA)
        else $error("no master abort after five clocks");
    a_ma_status: assert property ((ev_ma && req_q.kind != PBT_K_SC && !req_q.up)
        |=> stat_q[PBT_SEC_OFS + PBT_S_RMA])
        else $error("received master abort not set");
    a_ma_ones: assert property ((ev_ma && is_dly && !ctrl_q[PBT_C_MAM])
        |=> ans_q == PBT_A_TRDY && data_q == PBT_ALL_ONES)
        else $error("mode 0 master abort answer wrong");
    a_ma_tabort: assert property ((ev_ma && is_dly && ctrl_q[PBT_C_MAM])
        |=> ans_q == PBT_A_TABORT && st_q == S_DONE)
        else $error("mode 1 master abort answer wrong");
    a_pw_ma_drop: assert property ((ev_ma && req_q.kind == PBT_K_PW)
        |=> st_q == S_IDLE && req_ready)
        else $error("posted write kept after master abort");
    a_pw_ma_serr: assert property ((ev_ma && req_q.kind == PBT_K_PW
        && ctrl_q[PBT_C_MAM] && ctrl_q[PBT_C_SERR_EN] && !ctrl_q[PBT_C_DIS_PWMA])
        |=> !sys_err_n && stat_q[PBT_S_SSE])
        else $error("system error missing on posted master abort");
    a_sc_quiet: assert property ((ev_ma && req_q.kind == PBT_K_SC)
        |-> stat_set == 8'h00)
        else $error("special cycle abort touched status");
    a_busy_retry: assert property ((ini_attempt && (st_q == S_ADDR || st_q == S_DATA))
        |=> ini_ans.valid && ini_ans.ans == PBT_A_RETRY)
        else $error("busy attempt not retried");
    a_retry_addr: assert property ((ev_retry && !lim_hit)
        |=> ##1 st_q == S_ADDR && tgt_out.addr == $past(tgt_out.addr, 2))
        else $error("retry changed start address");
    a_limit_drop: assert property ((ev_retry && lim_hit && is_dly)
        |=> st_q == S_DONE && ans_q == PBT_A_TABORT)
        else $error("limit did not drop delayed write");

    c_master_abort: cover property (ev_ma);
    c_retry_reissue: cover property (ev_retry ##2 st_q == S_ADDR);
    c_disc_reissue: cover property (ev_disc_pw ##[1:8] st_q == S_DATA);
    c_done_answer: cover property (st_q == S_DONE ##1 ini_ans.valid);
endmodule : pbt_term

// ===== testbench/pbt_tgt_model.sv
`timescale 1ns/1ps
// target on the far bus: mode holds for the first n_bad attempts, then normal
module pbt_tgt_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench control: 0 silent, 1 normal, 2 retry, 3 disconnect, 4 abort
    input wire logic [2:0] mode,
    input wire logic [3:0] n_bad,
    input wire logic [1:0] slow,
    input wire logic restart,
    // target bus
    input wire pbt_pkg::pbt_tout_t tgt_out,
    output pbt_pkg::pbt_tin_t tgt_in
);
    import pbt_pkg::*;

    logic act_q;
    logic [3:0] n_att_q;
    logic [1:0] wait_q;
    logic [2:0] m;

    assign m = (n_att_q < n_bad) ? mode : 3'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_q <= 1'b0;
            n_att_q <= 4'h0;
            wait_q <= 2'h0;
            tgt_in <= '0;
        end else begin
            act_q <= tgt_out.act;
            if (restart) begin
                n_att_q <= 4'h0;
            end else if (act_q && !tgt_out.act) begin
                n_att_q <= n_att_q + 4'h1;
            end
            if (!tgt_out.act) begin
                // released lines sit at the pulled-up, deasserted level
                tgt_in <= '0;
                wait_q <= 2'h0;
            end else if (tgt_out.frame) begin
                // slow decode still answers inside the five-clock window
                wait_q <= wait_q + 2'h1;
                tgt_in.devsel <= (m != 3'h0) && (wait_q >= slow);
            end else begin
                case (m)
                    3'h2: tgt_in <= '{devsel: 1'b1, trdy: 1'b0, stop: 1'b1};
                    3'h3: tgt_in <= '{devsel: 1'b1, trdy: 1'b1, stop: 1'b1};
                    // devsel was shown in the address phase before the abort
                    3'h4: tgt_in <= '{devsel: 1'b0, trdy: 1'b0, stop: 1'b1};
                    default: tgt_in <= '{devsel: 1'b1, trdy: 1'b1, stop: 1'b0};
                endcase
            end
        end
    end
endmodule : pbt_tgt_model

// ===== testbench/pbt_term_tb.sv
`timescale 1ns/1ps
module pbt_term_tb;
    import pbt_pkg::*;

    localparam int LIM = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic req_valid = 1'b0;
    pbt_req_t req = '0;
    logic req_ready;
    pbt_tin_t tgt_in;
    pbt_tout_t tgt_out;
    logic ini_attempt = 1'b0;
    logic ini_expired = 1'b0;
    pbt_ians_t ini_ans;
    logic sys_err_n;
    logic [2:0] mode = 3'h1;
    logic [3:0] n_bad = 4'h0;
    logic [1:0] slow = 2'h0;
    logic fr_q = 1'b0;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_serr = 0;
    logic [63:0] qa[$];
    logic [63:0] qr[$];
    logic [63:0] qf[$];

    always #25 pclk = ~pclk;

    pbt_term #(.RETRY_LIMIT(LIM)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .tgt_in(tgt_in), .tgt_out(tgt_out), .ini_attempt(ini_attempt),
        .ini_expired(ini_expired), .ini_ans(ini_ans), .sys_err_n(sys_err_n));

    pbt_tgt_model u_tgt (.pclk(pclk), .presetn(presetn), .mode(mode), .n_bad(n_bad),
        .slow(slow), .restart(req_valid), .tgt_out(tgt_out), .tgt_in(tgt_in));

    // ------------------------------------------------------------
    // checking
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic take(input string what, ref logic [63:0] q[$], input logic [63:0] seen);
        // a result nobody announced can never match
        if (q.size() == 0) chk(what, seen, ~seen);
        else chk(what, seen, q.pop_front());
    endtask : take

    always @(posedge pclk) begin
        fr_q <= tgt_out.frame;
        if (sys_err_n === 1'b0) n_serr++;
        if (psel && penable && pready === 1'b1 && !pwrite)
            take("read", qr, {31'h0, pslverr, prdata});
        if (tgt_out.frame === 1'b1 && fr_q !== 1'b1)
            take("frame", qf, {28'h0, tgt_out.addr, tgt_out.cmd});
        if (ini_ans.valid === 1'b1)
            take("answer", qa, {29'h0, ini_ans.ans, ini_ans.data});
    end

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // drivers
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        if (!wr) qr.push_back({31'h0, ad > PBT_OFS_ATT, d});
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run(input pbt_kind_t k, input logic [3:0] cmd, input logic [7:0] ndw,
        input logic mul, input logic up, input logic [2:0] md, input logic [3:0] nb,
        input int nfr, input pbt_ans_t ans, input logic [31:0] dat, input logic [7:0] stat,
        input int se);
        logic [31:0] a;
        int s0;
        int n;
        a = $urandom & 32'hFFFF_FFF0;
        s0 = n_serr;
        if (md == 3'h3) begin
            qf.push_back({28'h0, a, cmd});
            qf.push_back({28'h0, a + 32'h4, PBT_CMD_MW});
        end else begin
            repeat (nfr) qf.push_back({28'h0, a, cmd});
        end
        if (k != PBT_K_PW) qa.push_back({29'h0, PBT_A_RETRY, 32'h0});
        @(posedge pclk);
        mode <= md;
        n_bad <= nb;
        req <= '{k, a, cmd, ndw, mul, up};
        req_valid <= 1'b1;
        @(posedge pclk);
        req_valid <= 1'b0;
        // an initiator repeat while the engine still works is retried
        ini_attempt <= (k != PBT_K_PW);
        @(posedge pclk);
        ini_attempt <= 1'b0;
        n = 0;
        while (n < 3) begin
            @(posedge pclk);
            n = tgt_out.act ? 0 : n + 1;
        end
        if (k != PBT_K_PW) begin
            qa.push_back({29'h0, ans, dat});
            @(posedge pclk);
            ini_attempt <= 1'b1;
            @(posedge pclk);
            ini_attempt <= 1'b0;
        end
        repeat (3) @(posedge pclk);
        chk("ready", req_ready, 1'b1);
        chk("serr", n_serr - s0, se);
        apb(1'b0, PBT_OFS_STAT, stat);
        apb(1'b1, PBT_OFS_STAT, 32'hFF);
        $display("test %s done", k.name());
    endtask : run

    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        finish_test();
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hCC2876D9));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("ready rst", req_ready, 1'b1);
        chk("serr rst", sys_err_n, 1'b1);
        apb(1'b0, PBT_OFS_CTRL, 32'h0);
        apb(1'b0, PBT_OFS_STAT, 32'h0);
        apb(1'b0, PBT_OFS_ATT, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        slow <= 2'h2;
        run(PBT_K_DW, 4'h7, 8'h01, 1'b1, 1'b0, 3'h1, 4'h0, 1, PBT_A_DISC, 32'h0, 8'h00, 0);
        slow <= 2'h0;
        run(PBT_K_DW, 4'h7, 8'h01, 1'b0, 1'b1, 3'h1, 4'h0, 1, PBT_A_TRDY, 32'h0, 8'h00, 0);
        run(PBT_K_DR, 4'h6, 8'h01, 1'b0, 1'b0, 3'h0, 4'hF, 1, PBT_A_TRDY, PBT_ALL_ONES, 8'h10, 0);
        run(PBT_K_DW, 4'h7, 8'h01, 1'b0, 1'b0, 3'h2, 4'h2, 3, PBT_A_TRDY, 32'h0, 8'h00, 0);
        apb(1'b0, PBT_OFS_ATT, 32'h2);
        run(PBT_K_DW, 4'h7, 8'h01, 1'b0, 1'b1, 3'h4, 4'hF, 1, PBT_A_TABORT, 32'h0, 8'h42, 0);
        run(PBT_K_SC, 4'h1, 8'h01, 1'b1, 1'b0, 3'h0, 4'hF, 1, PBT_A_DISC, 32'h0, 8'h00, 0);
        run(PBT_K_PW, 4'h7, 8'h02, 1'b0, 1'b0, 3'h2, 4'h1, 2, PBT_A_NONE, 32'h0, 8'h00, 0);
        run(PBT_K_PW, 4'hF, 8'h03, 1'b0, 1'b0, 3'h3, 4'h1, 2, PBT_A_NONE, 32'h0, 8'h00, 0);
        run(PBT_K_PW, 4'h7, 8'h01, 1'b0, 1'b0, 3'h0, 4'hF, 1, PBT_A_NONE, 32'h0, 8'h10, 0);
        apb(1'b1, PBT_OFS_CTRL, 32'h3);
        apb(1'b0, PBT_OFS_CTRL, 32'h3);
        run(PBT_K_DW, 4'h7, 8'h01, 1'b0, 1'b0, 3'h0, 4'hF, 1, PBT_A_TABORT, 32'h0, 8'h14, 0);
        run(PBT_K_PW, 4'h7, 8'h01, 1'b0, 1'b1, 3'h0, 4'hF, 1, PBT_A_NONE, 32'h0, 8'h09, 1);
        run(PBT_K_PW, 4'h7, 8'h02, 1'b0, 1'b0, 3'h4, 4'hF, 1, PBT_A_NONE, 32'h0, 8'h28, 1);
        run(PBT_K_DW, 4'h7, 8'h01, 1'b0, 1'b0, 3'h2, 4'hF, 4, PBT_A_TABORT, 32'h0, 8'h0C, 1);
        run(PBT_K_PW, 4'h7, 8'h01, 1'b0, 1'b1, 3'h2, 4'hF, 4, PBT_A_NONE, 32'h0, 8'h08, 1);
        apb(1'b1, PBT_OFS_CTRL, 32'h7);
        run(PBT_K_PW, 4'h7, 8'h01, 1'b0, 1'b1, 3'h0, 4'hF, 1, PBT_A_NONE, 32'h0, 8'h01, 0);
        // master timeout drops a held completion, later repeat sees idle
        qf.push_back({28'h0, 32'h40, 4'h7});
        qa.push_back({29'h0, PBT_A_NONE, 32'h0});
        @(posedge pclk);
        mode <= 3'h1;
        req <= '{PBT_K_DW, 32'h40, 4'h7, 8'h01, 1'b0, 1'b0};
        req_valid <= 1'b1;
        @(posedge pclk);
        req_valid <= 1'b0;
        repeat (12) @(posedge pclk);
        ini_expired <= 1'b1;
        @(posedge pclk);
        ini_expired <= 1'b0;
        ini_attempt <= 1'b1;
        @(posedge pclk);
        ini_attempt <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("expired", req_ready, 1'b1);
        $display("test expiry done");
        repeat (2) @(posedge pclk);
        chk("left over", qa.size() + qr.size() + qf.size(), 0);
        finish_test();
    end
endmodule : pbt_term_tb
